// ### shared/dpc_pkg.sv
// Constants shared by the dual data pointer block and its submodules.
// Assumes a byte-wide special-register bus driven by the processor core.
package dpc_pkg;

    // Register addresses on the core's special-register bus
    localparam logic [7:0] ADDR_CTRL = 8'hA7;
    localparam logic [7:0] ADDR_LOW = 8'hA4;
    localparam logic [7:0] ADDR_HIGH = 8'hA5;
    localparam logic [7:0] ADDR_PAGE = 8'hA6;

    // Control register field positions
    localparam int SEL_BIT = 0;
    localparam int UNIMPL_BIT = 1;
    localparam int MAIN_MODE_LSB = 2;
    localparam int SHADOW_MODE_LSB = 4;
    localparam int SWAP_BIT = 6;
    localparam int RSVD_BIT = 7;

    // Control register reset value and mask of stored bits
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] CTRL_WMASK = 8'h7D;

    // Pointer modification modes
    localparam logic [1:0] MODE_PLAIN = 2'h0;
    localparam logic [1:0] MODE_INC = 2'h1;
    localparam logic [1:0] MODE_DEC = 2'h2;
    localparam logic [1:0] MODE_TOGGLE = 2'h3;

    // Pointer geometry and values
    localparam int PTR_W = 24;
    localparam int NUM_BYTES = 3;
    localparam int NUM_PTR = 2;
    localparam int MAIN_IDX = 0;
    localparam int SHADOW_IDX = 1;
    localparam logic [23:0] PTR_RESET = 24'h000000;
    localparam logic [23:0] PTR_ONE = 24'h000001;
    localparam logic [23:0] PTR_ALL_ONES = 24'hFFFFFF;
    localparam logic [7:0] RDATA_RESET = 8'h00;

    // Kind of memory move reported by the instruction sequencer
    typedef enum logic [1:0] {
        MV_XDATA_PTR = 2'h0,
        MV_CODE_PTR = 2'h1,
        MV_CODE_PC = 2'h2,
        MV_XDATA_IND = 2'h3
    } dpc_move_t;

endpackage : dpc_pkg

// ### shared/dpc_ptr_if.sv
// Carrier between the pointer block top and one pointer storage unit.
// Assumes one instance per pointer, all on the core clock.
`timescale 1ns/10ps
`default_nettype none

interface dpc_ptr_if;
    logic [1:0] mode;
    logic step;
    logic inc;
    logic [2:0] byte_we;
    logic [7:0] byte_wdata;
    logic [23:0] value;

    modport unit (input mode, input step, input inc, input byte_we, input byte_wdata, output value);
    modport ctrl (output mode, output step, output inc, output byte_we, output byte_wdata, input value);
endinterface : dpc_ptr_if

`default_nettype wire

// ### rtl/dpc_ptr_unit.sv
// One 24-bit data pointer with byte writes and automatic modification.
// Assumes the top asserts at most one of byte write, step or inc meaningfully.
`timescale 1ns/10ps
`default_nettype none

module dpc_ptr_unit (
    // Clock and reset
    input wire logic core_clk,
    input wire logic arst_n,
    // Control from the top
    dpc_ptr_if.unit pif
);

    logic [23:0] value_q;
    logic [23:0] value_d;

    // Next value: byte write beats a move step, which beats a plain increment
    always_comb begin
        value_d = value_q;
        if (|pif.byte_we) begin
            for (int b = 0; b < dpc_pkg::NUM_BYTES; b++) begin
                if (pif.byte_we[b]) begin
                    value_d[b*8 +: 8] = pif.byte_wdata;
                end
            end
        end else if (pif.step) begin
            unique case (pif.mode)
                dpc_pkg::MODE_PLAIN: value_d = value_q;
                dpc_pkg::MODE_INC: value_d = value_q + dpc_pkg::PTR_ONE;
                dpc_pkg::MODE_DEC: value_d = value_q - dpc_pkg::PTR_ONE;
                dpc_pkg::MODE_TOGGLE: value_d = {value_q[23:1], ~value_q[0]};
            endcase
        end else if (pif.inc) begin
            value_d = value_q + dpc_pkg::PTR_ONE; // Wraps modulo 2^24
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            value_q <= dpc_pkg::PTR_RESET;
        end else begin
            value_q <= value_d;
        end
    end

    assign pif.value = value_q;

endmodule : dpc_ptr_unit

`default_nettype wire

// ### rtl/dpc_ctrl_reg.sv
// Pointer control register: select, two mode fields and auto-swap enable.
// Assumes the top decodes the register address and qualifies the swap pulse.
`timescale 1ns/10ps
`default_nettype none

module dpc_ctrl_reg (
    // Clock and reset
    input wire logic core_clk,
    input wire logic arst_n,
    // Software write
    input wire logic wr_en,
    input wire logic [7:0] wr_data,
    // Automatic select flip after a qualifying move
    input wire logic swap,
    // Register contents
    output logic [7:0] ctrl_value
);

    logic [7:0] ctrl_q;
    logic [7:0] ctrl_d;

    // Bits 1 and 7 never store, so a read-add-write only touches the select bit
    always_comb begin
        ctrl_d = ctrl_q;
        if (wr_en) begin
            ctrl_d = wr_data & dpc_pkg::CTRL_WMASK;
        end else if (swap) begin
            ctrl_d[dpc_pkg::SEL_BIT] = ~ctrl_q[dpc_pkg::SEL_BIT];
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl_q <= dpc_pkg::CTRL_RESET;
        end else begin
            ctrl_q <= ctrl_d;
        end
    end

    assign ctrl_value = ctrl_q;

endmodule : dpc_ctrl_reg

`default_nettype wire

// ### rtl/dpc_top.sv
// Dual data pointer block: control register, two pointers, register access.
// Assumes the core's special-register bus and move reports are on core_clk.
`timescale 1ns/10ps
`default_nettype none

module dpc_top (
    // Clock and reset
    input wire logic core_clk,
    input wire logic arst_n,
    // Special-register bus from the core
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    output logic sfr_hit,
    // Move and pointer-increment reports from the sequencer
    input wire logic move_valid,
    input wire logic [1:0] move_kind,
    input wire logic ptr_inc,
    // Pointer seen by the core
    output logic [23:0] active_pointer,
    output logic pointer_select
);

    logic [7:0] ctrl_value;
    logic sel;
    logic qualify;
    logic ctrl_we;
    logic swap;
    logic wr_low;
    logic wr_high;
    logic wr_page;
    logic wr_any_ptr;
    logic [23:0] ptr_main;
    logic [23:0] ptr_shadow;
    logic [1:0] mode_main;
    logic [1:0] mode_shadow;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    logic [23:0] ptr_val [dpc_pkg::NUM_PTR];

    // Address decode
    assign ctrl_we = sfr_wr && (sfr_addr == dpc_pkg::ADDR_CTRL);
    assign wr_low = sfr_wr && (sfr_addr == dpc_pkg::ADDR_LOW);
    assign wr_high = sfr_wr && (sfr_addr == dpc_pkg::ADDR_HIGH);
    assign wr_page = sfr_wr && (sfr_addr == dpc_pkg::ADDR_PAGE);
    assign wr_any_ptr = wr_low || wr_high || wr_page;
    assign sfr_hit = (sfr_addr == dpc_pkg::ADDR_CTRL) || (sfr_addr == dpc_pkg::ADDR_LOW)
                     || (sfr_addr == dpc_pkg::ADDR_HIGH) || (sfr_addr == dpc_pkg::ADDR_PAGE);

    // Only moves addressed through the data pointer count
    assign qualify = move_valid && ((move_kind == dpc_pkg::MV_XDATA_PTR)
                     || (move_kind == dpc_pkg::MV_CODE_PTR));

    // Swap uses the old select, so the step lands on the used pointer first
    assign swap = qualify && ctrl_value[dpc_pkg::SWAP_BIT];

    // Control register
    dpc_ctrl_reg u_ctrl (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .wr_en(ctrl_we),
        .wr_data(sfr_wdata),
        .swap(swap),
        .ctrl_value(ctrl_value)
    );

    assign sel = ctrl_value[dpc_pkg::SEL_BIT];
    assign mode_main = ctrl_value[dpc_pkg::MAIN_MODE_LSB +: 2];
    assign mode_shadow = ctrl_value[dpc_pkg::SHADOW_MODE_LSB +: 2];

    // One storage unit per pointer; only the selected one sees core accesses
    dpc_ptr_if pif [dpc_pkg::NUM_PTR] ();

    for (genvar i = 0; i < dpc_pkg::NUM_PTR; i++) begin : g_ptr
        logic mine;
        assign mine = (sel == 1'(i));
        if (i == dpc_pkg::MAIN_IDX) begin : g_main
            assign pif[i].mode = mode_main;
        end else begin : g_shadow
            assign pif[i].mode = mode_shadow;
        end
        assign pif[i].step = qualify && mine;
        assign pif[i].inc = ptr_inc && mine;
        assign pif[i].byte_we = {wr_page, wr_high, wr_low} & {3{mine}};
        assign pif[i].byte_wdata = sfr_wdata;
        assign ptr_val[i] = pif[i].value;

        dpc_ptr_unit u_unit (
            .core_clk(core_clk),
            .arst_n(arst_n),
            .pif(pif[i])
        );
    end

    assign ptr_main = ptr_val[dpc_pkg::MAIN_IDX];
    assign ptr_shadow = ptr_val[dpc_pkg::SHADOW_IDX];

    // Selected pointer is what the core sees
    assign active_pointer = sel ? ptr_shadow : ptr_main;
    assign pointer_select = sel;

    // Read data is registered; unmapped addresses read zero
    always_comb begin
        rdata_d = rdata_q;
        if (sfr_rd) begin
            unique case (sfr_addr)
                dpc_pkg::ADDR_CTRL: rdata_d = ctrl_value;
                dpc_pkg::ADDR_LOW: rdata_d = active_pointer[7:0];
                dpc_pkg::ADDR_HIGH: rdata_d = active_pointer[15:8];
                dpc_pkg::ADDR_PAGE: rdata_d = active_pointer[23:16];
                default: rdata_d = dpc_pkg::RDATA_RESET;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            rdata_q <= dpc_pkg::RDATA_RESET;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign sfr_rdata = rdata_q;

    // Checks on the block's own behaviour
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!arst_n);

    // Select written alone picks which pointer is visible next cycle
    property p_sel_view;
        ctrl_we && !qualify && !ptr_inc && !wr_any_ptr
            |=> active_pointer == ($past(sfr_wdata[0]) ? $past(ptr_shadow) : $past(ptr_main));
    endproperty
    a_sel_view: assert property (p_sel_view) else $error("visible pointer does not follow select");

    // Shadow increment mode after a qualifying move
    property p_shadow_inc;
        qualify && sel && (mode_shadow == dpc_pkg::MODE_INC) && !wr_any_ptr
            |=> (ptr_shadow == 24'($past(ptr_shadow) + dpc_pkg::PTR_ONE)) && $stable(ptr_main);
    endproperty
    a_shadow_inc: assert property (p_shadow_inc) else $error("shadow pointer not incremented");

    // Shadow plain mode leaves the pointer alone
    property p_shadow_plain;
        qualify && sel && (mode_shadow == dpc_pkg::MODE_PLAIN) && !wr_any_ptr
            |=> $stable(ptr_shadow);
    endproperty
    a_shadow_plain: assert property (p_shadow_plain) else $error("shadow pointer changed in plain mode");

    // Main decrement mode after a qualifying move
    property p_main_dec;
        qualify && !sel && (mode_main == dpc_pkg::MODE_DEC) && !wr_any_ptr
            |=> (ptr_main == 24'($past(ptr_main) - dpc_pkg::PTR_ONE)) && $stable(ptr_shadow);
    endproperty
    a_main_dec: assert property (p_main_dec) else $error("main pointer not decremented");

    // Toggle mode flips bit 0 only
    property p_main_toggle;
        qualify && !sel && (mode_main == dpc_pkg::MODE_TOGGLE) && !wr_any_ptr
            |=> (ptr_main[23:1] == $past(ptr_main[23:1])) && (ptr_main[0] != $past(ptr_main[0]));
    endproperty
    a_main_toggle: assert property (p_main_toggle) else $error("toggle mode altered wrong bits");

    // Swap follows the enable bit on each qualifying move
    property p_swap;
        qualify && !ctrl_we
            |=> sel == ($past(ctrl_value[dpc_pkg::SWAP_BIT]) ? !$past(sel) : $past(sel));
    endproperty
    a_swap: assert property (p_swap) else $error("select swap wrong after move");

    // Non-pointer moves change nothing
    property p_no_qualify;
        move_valid && !qualify && !ctrl_we && !wr_any_ptr && !ptr_inc
            |=> $stable(ptr_main) && $stable(ptr_shadow) && $stable(ctrl_value);
    endproperty
    a_no_qualify: assert property (p_no_qualify) else $error("non-pointer move changed state");

    // Unimplemented bit never stores, upper fields take the written value
    property p_bit1;
        ctrl_we |=> !ctrl_value[dpc_pkg::UNIMPL_BIT] && (ctrl_value[6:2] == $past(sfr_wdata[6:2]));
    endproperty
    a_bit1: assert property (p_bit1) else $error("control write carried into fields");

    // Reserved bit reads zero
    property p_bit7;
        sfr_rd && (sfr_addr == dpc_pkg::ADDR_CTRL) |=> !sfr_rdata[dpc_pkg::RSVD_BIT];
    endproperty
    a_bit7: assert property (p_bit7) else $error("reserved bit read as one");

    // First cycle after reset release shows cleared state
    property p_reset;
        !$past(arst_n) |-> (ctrl_value == dpc_pkg::CTRL_RESET) && !pointer_select;
    endproperty
    a_reset: assert property (p_reset) else $error("control not cleared by reset");

    // Pointer increment goes to the selected pointer only
    property p_inc_selected;
        ptr_inc && !move_valid && !wr_any_ptr && !ctrl_we
            |=> ($past(sel) ? ($stable(ptr_main) && ptr_shadow == 24'($past(ptr_shadow) + dpc_pkg::PTR_ONE))
                            : ($stable(ptr_shadow) && ptr_main == 24'($past(ptr_main) + dpc_pkg::PTR_ONE)));
    endproperty
    a_inc_selected: assert property (p_inc_selected) else $error("increment hit wrong pointer");

    // Step lands on the used pointer, then the other one becomes visible
    property p_step_then_swap;
        qualify && !sel && ctrl_value[dpc_pkg::SWAP_BIT] && (mode_main == dpc_pkg::MODE_INC)
            && !wr_any_ptr && !ctrl_we
            |=> sel && (ptr_main == 24'($past(ptr_main) + dpc_pkg::PTR_ONE))
                && (active_pointer == $past(ptr_shadow));
    endproperty
    a_step_then_swap: assert property (p_step_then_swap) else $error("step and swap out of order");

    // Full-width wrap on increment
    property p_wrap;
        qualify && !sel && (mode_main == dpc_pkg::MODE_INC) && !wr_any_ptr
            && (ptr_main == dpc_pkg::PTR_ALL_ONES)
            |=> ptr_main == dpc_pkg::PTR_RESET;
    endproperty
    a_wrap: assert property (p_wrap) else $error("pointer did not wrap at 24 bits");

    // Main increment mode after a qualifying move
    property p_main_inc;
        qualify && !sel && (mode_main == dpc_pkg::MODE_INC) && !wr_any_ptr
            |=> (ptr_main == 24'($past(ptr_main) + dpc_pkg::PTR_ONE)) && $stable(ptr_shadow);
    endproperty
    a_main_inc: assert property (p_main_inc) else $error("main pointer not incremented");

    // Shadow decrement mode after a qualifying move
    property p_shadow_dec;
        qualify && sel && (mode_shadow == dpc_pkg::MODE_DEC) && !wr_any_ptr
            |=> (ptr_shadow == 24'($past(ptr_shadow) - dpc_pkg::PTR_ONE)) && $stable(ptr_main);
    endproperty
    a_shadow_dec: assert property (p_shadow_dec) else $error("shadow pointer not decremented");

    // Shadow toggle flips bit 0 only and spares the main pointer
    property p_shadow_toggle;
        qualify && sel && (mode_shadow == dpc_pkg::MODE_TOGGLE) && !wr_any_ptr
            |=> (ptr_shadow[23:1] == $past(ptr_shadow[23:1])) && (ptr_shadow[0] != $past(ptr_shadow[0]))
                && $stable(ptr_main);
    endproperty
    a_shadow_toggle: assert property (p_shadow_toggle) else $error("shadow toggle altered wrong bits");

    // Main plain mode leaves the pointer alone, even with an increment pending
    property p_main_plain;
        qualify && !sel && (mode_main == dpc_pkg::MODE_PLAIN) && !wr_any_ptr
            |=> $stable(ptr_main);
    endproperty
    a_main_plain: assert property (p_main_plain) else $error("main pointer changed in plain mode");

    // Clear enable bit keeps the select where it was
    property p_no_swap;
        qualify && !ctrl_value[dpc_pkg::SWAP_BIT] && !ctrl_we
            |=> $stable(sel);
    endproperty
    a_no_swap: assert property (p_no_swap) else $error("select swapped with swap disabled");

    // Low byte write lands in the main pointer while it is selected
    property p_low_write_main;
        wr_low && !sel
            |=> (ptr_main[7:0] == $past(sfr_wdata)) && $stable(ptr_shadow);
    endproperty
    a_low_write_main: assert property (p_low_write_main) else $error("low byte missed main pointer");

    // Page byte write lands in the shadow pointer while it is selected
    property p_page_write_shadow;
        wr_page && sel
            |=> (ptr_shadow[23:16] == $past(sfr_wdata)) && $stable(ptr_main);
    endproperty
    a_page_write_shadow: assert property (p_page_write_shadow) else $error("page byte missed shadow pointer");

    // Page byte read returns the pointer selected when the strobe was taken
    property p_read_page;
        sfr_rd && (sfr_addr == dpc_pkg::ADDR_PAGE)
            |=> sfr_rdata == ($past(sel) ? $past(ptr_shadow[23:16]) : $past(ptr_main[23:16]));
    endproperty
    a_read_page: assert property (p_read_page) else $error("page read from wrong pointer");

    // Control read shows the select and never the missing bit
    property p_ctrl_read;
        sfr_rd && (sfr_addr == dpc_pkg::ADDR_CTRL)
            |=> !sfr_rdata[dpc_pkg::UNIMPL_BIT] && (sfr_rdata[dpc_pkg::SEL_BIT] == $past(sel));
    endproperty
    a_ctrl_read: assert property (p_ctrl_read) else $error("control read shows wrong low bits");

    // Reset also leaves plain modes, no swap and a zero pointer in view
    property p_reset_fields;
        !$past(arst_n)
            |-> (mode_main == dpc_pkg::MODE_PLAIN) && (mode_shadow == dpc_pkg::MODE_PLAIN)
                && !ctrl_value[dpc_pkg::SWAP_BIT] && (active_pointer == dpc_pkg::PTR_RESET);
    endproperty
    a_reset_fields: assert property (p_reset_fields) else $error("fields not cleared by reset");

    // Pointer increment also wraps across all three bytes
    property p_inc_wrap;
        ptr_inc && !move_valid && !wr_any_ptr && !ctrl_we && (active_pointer == dpc_pkg::PTR_ALL_ONES)
            |=> active_pointer == dpc_pkg::PTR_RESET;
    endproperty
    a_inc_wrap: assert property (p_inc_wrap) else $error("increment did not wrap at 24 bits");

    // Decrement from zero borrows through every byte
    property p_dec_borrow;
        qualify && !sel && (mode_main == dpc_pkg::MODE_DEC) && !wr_any_ptr
            && (ptr_main == dpc_pkg::PTR_RESET)
            |=> ptr_main == dpc_pkg::PTR_ALL_ONES;
    endproperty
    a_dec_borrow: assert property (p_dec_borrow) else $error("decrement did not borrow at 24 bits");

endmodule : dpc_top

`default_nettype wire

// ### tb/dpc_seq_model.sv
// Model of the core's instruction sequencer: register accesses, moves, increments.
// Assumes the caller drives it from one process and the block answers on core_clk.
`timescale 1ns/10ps
`default_nettype none

module dpc_seq_model (
    // Clock
    input wire logic core_clk,
    // Special-register bus
    output logic [7:0] sfr_addr,
    output logic sfr_wr,
    output logic sfr_rd,
    output logic [7:0] sfr_wdata,
    input wire logic [7:0] sfr_rdata,
    input wire logic sfr_hit,
    // Move and increment reports
    output logic move_valid,
    output logic [1:0] move_kind,
    output logic ptr_inc
);
    // Quiet bus at time zero
    initial begin
        sfr_addr = 8'h00;
        sfr_wr = 1'b0;
        sfr_rd = 1'b0;
        sfr_wdata = 8'h00;
        move_valid = 1'b0;
        move_kind = 2'h0;
        ptr_inc = 1'b0;
    end

    // Idle qualifiers flip so a stale value can never pass for a live one
    task automatic scramble();
        sfr_addr = ~sfr_addr;
        sfr_wdata = ~sfr_wdata;
        move_kind = ~move_kind;
    endtask : scramble

    // Strobes rise after one falling edge and drop at the next one
    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        @(negedge core_clk);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        @(negedge core_clk);
        sfr_wr = 1'b0;
        scramble();
    endtask : reg_write

    // Read data is taken one cycle after the strobe edge
    task automatic reg_read(input logic [7:0] a, output logic [7:0] d, output logic h);
        @(negedge core_clk);
        sfr_addr = a;
        sfr_rd = 1'b1;
        @(negedge core_clk);
        sfr_rd = 1'b0;
        d = sfr_rdata;
        h = sfr_hit;
        scramble();
    endtask : reg_read

    task automatic do_move(input logic [1:0] k);
        @(negedge core_clk);
        move_kind = k;
        move_valid = 1'b1;
        @(negedge core_clk);
        move_valid = 1'b0;
        scramble();
    endtask : do_move

    task automatic do_inc();
        @(negedge core_clk);
        ptr_inc = 1'b1;
        @(negedge core_clk);
        ptr_inc = 1'b0;
    endtask : do_inc
endmodule : dpc_seq_model

`default_nettype wire

// ### tb/dpc_top_bench.sv
// Self-checking bench for the dual data pointer block, random plus corner cases.
// Assumes dpc_seq_model drives the core side at falling clock edges.
`timescale 1ns/10ps
`default_nettype none

module dpc_top_bench;
    logic core_clk;
    logic arst_n;
    logic [7:0] sfr_addr;
    logic sfr_wr;
    logic sfr_rd;
    logic [7:0] sfr_wdata;
    logic [7:0] sfr_rdata;
    logic sfr_hit;
    logic move_valid;
    logic [1:0] move_kind;
    logic ptr_inc;
    logic [23:0] active_pointer;
    logic pointer_select;
    logic [7:0] e_ctrl;
    logic [23:0] e_ptr [2];
    logic [31:0] rnd;
    int n_errors;
    int checked;

    dpc_top DUT (.core_clk(core_clk), .arst_n(arst_n), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
        .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit),
        .move_valid(move_valid), .move_kind(move_kind), .ptr_inc(ptr_inc),
        .active_pointer(active_pointer), .pointer_select(pointer_select));

    dpc_seq_model m (.core_clk(core_clk), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
        .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit), .move_valid(move_valid),
        .move_kind(move_kind), .ptr_inc(ptr_inc));

    // 40 MHz core clock
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end

    function automatic logic [31:0] next_rnd(input logic [31:0] r);
        return {r[30:0], r[31] ^ r[21] ^ r[1] ^ r[0]};
    endfunction : next_rnd

    // Expected pointer after a qualifying move in mode md
    function automatic logic [23:0] stepped(input logic [23:0] p, input logic [1:0] md);
        case (md)
            dpc_pkg::MODE_INC: return p + 24'h000001;
            dpc_pkg::MODE_DEC: return p - 24'h000001;
            dpc_pkg::MODE_TOGGLE: return {p[23:1], ~p[0]};
            default: return p;
        endcase
    endfunction : stepped

    function automatic logic [7:0] exp_read(input logic [7:0] a);
        if (a == dpc_pkg::ADDR_CTRL) return e_ctrl;
        if (a >= dpc_pkg::ADDR_LOW && a <= dpc_pkg::ADDR_PAGE)
            return e_ptr[e_ctrl[0]][8 * (a - dpc_pkg::ADDR_LOW) +: 8];
        return 8'h00;
    endfunction : exp_read

    task automatic check(input logic [23:0] got, input logic [23:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : check

    task automatic check_state();
        check(active_pointer, e_ptr[e_ctrl[0]], "pointer");
        check({23'h000000, pointer_select}, {23'h000000, e_ctrl[0]}, "select");
    endtask : check_state

    task automatic op_write(input logic [7:0] a, input logic [7:0] d);
        m.reg_write(a, d);
        if (a == dpc_pkg::ADDR_CTRL) e_ctrl = d & dpc_pkg::CTRL_WMASK;
        else if (a >= dpc_pkg::ADDR_LOW && a <= dpc_pkg::ADDR_PAGE)
            e_ptr[e_ctrl[0]][8 * (a - dpc_pkg::ADDR_LOW) +: 8] = d;
        check_state();
    endtask : op_write

    task automatic op_read(input logic [7:0] a);
        logic [7:0] d;
        logic h;
        m.reg_read(a, d, h);
        check({16'h0000, d}, {16'h0000, exp_read(a)}, "read data");
        check({23'h000000, h}, {23'h000000, a >= dpc_pkg::ADDR_LOW && a <= dpc_pkg::ADDR_CTRL}, "hit");
    endtask : op_read

    // Read-add-write of the control register must flip only the select bit
    task automatic op_ctrl_inc();
        logic [7:0] d;
        logic h;
        m.reg_read(dpc_pkg::ADDR_CTRL, d, h);
        m.reg_write(dpc_pkg::ADDR_CTRL, d + 8'h01);
        e_ctrl[0] = ~e_ctrl[0];
        check_state();
        op_read(dpc_pkg::ADDR_CTRL);
    endtask : op_ctrl_inc

    // Mode step lands on the used pointer before the select flips
    task automatic op_move(input logic [1:0] k);
        logic s;
        m.do_move(k);
        s = e_ctrl[0];
        if (k == 2'h0 || k == 2'h1) begin
            e_ptr[s] = stepped(e_ptr[s], s ? e_ctrl[5:4] : e_ctrl[3:2]);
            if (e_ctrl[6]) e_ctrl[0] = ~s;
        end
        check_state();
    endtask : op_move

    task automatic op_inc();
        m.do_inc();
        e_ptr[e_ctrl[0]] = e_ptr[e_ctrl[0]] + 24'h000001;
        check_state();
    endtask : op_inc

    task automatic set_ptr(input logic [23:0] v);
        op_write(dpc_pkg::ADDR_LOW, v[7:0]);
        op_write(dpc_pkg::ADDR_HIGH, v[15:8]);
        op_write(dpc_pkg::ADDR_PAGE, v[23:16]);
    endtask : set_ptr

    task automatic print_verdict();
        if (n_errors == 0 && checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : print_verdict

    // Watchdog at 20000 cycles, well beyond the expected run of about 1200 cycles
    initial begin
        #(25 * 20000);
        n_errors++;
        print_verdict();
    end

    initial begin
        n_errors = 0;
        checked = 0;
        rnd = 32'h0000D7D1;
        arst_n = 1'b0;
        e_ctrl = dpc_pkg::CTRL_RESET;
        e_ptr[0] = 24'h000000;
        e_ptr[1] = 24'h000000;
        repeat (2) @(negedge core_clk);
        arst_n = 1'b1;
        check_state();
        op_read(dpc_pkg::ADDR_CTRL);
        op_write(dpc_pkg::ADDR_CTRL, 8'hFF);
        op_read(dpc_pkg::ADDR_CTRL);
        // Every mode on both pointers, wrap values, every move kind
        for (int s = 0; s < 2; s++) begin
            for (int md = 0; md < 4; md++) begin
                for (int k = 0; k < 4; k++) begin
                    op_write(dpc_pkg::ADDR_CTRL, 8'(s | (md << 2) | (md << 4)));
                    set_ptr(k[0] ? 24'h000000 : 24'hFFFFFF);
                    op_move(2'(k));
                end
            end
        end
        // Copy loop style: both increment, auto swap on
        op_write(dpc_pkg::ADDR_CTRL, 8'h55);
        repeat (4) op_move(2'h1);
        set_ptr(24'hFFFFFF);
        op_inc();
        repeat (2) op_ctrl_inc();
        // Reset in mid-run must clear state that is no longer zero
        @(negedge core_clk);
        arst_n = 1'b0;
        e_ctrl = dpc_pkg::CTRL_RESET;
        e_ptr[0] = dpc_pkg::PTR_RESET;
        e_ptr[1] = dpc_pkg::PTR_RESET;
        @(negedge core_clk);
        arst_n = 1'b1;
        check_state();
        op_read(dpc_pkg::ADDR_CTRL);
        // Random mix of accesses, moves and increments
        for (int i = 0; i < 400; i++) begin
            rnd = next_rnd(rnd);
            case (rnd[2:0])
                3'h0, 3'h1: op_write(dpc_pkg::ADDR_CTRL, rnd[15:8]);
                3'h2: op_write(8'hA4 + 8'(rnd[17:16]), rnd[15:8]);
                3'h3, 3'h7: op_move(rnd[9:8]);
                3'h4: op_inc();
                3'h5: op_read(rnd[18] ? rnd[31:24] : 8'hA4 + 8'(rnd[17:16]));
                default: op_write(rnd[31:24], rnd[15:8]);
            endcase
        end
        print_verdict();
    end
endmodule : dpc_top_bench

`default_nettype wire
